//--- hw/sfwp_top.sv
// Write protection core of a serial NOR flash: write enable latch,
// block protection with freeze, and the one-time-programmable space.
// Assumes the serial front end presents one decoded command per cycle,
// each finishing in that cycle, and that reset_i is power-on reset.
`timescale 1ns/1ps
module sfwp_top #(
  parameter int unsigned MAIN_AW = sfwp_pkg::MAIN_AW
) (
  input  wire logic                 clk_i,             // Serial clock.
  input  wire logic                 reset_i,           // Power-on reset.
  input  wire logic                 hw_reset_i,        // Hardware reset.
  input  wire logic                 cmd_valid_i,       // Command strobe.
  input  wire sfwp_pkg::sfwp_cmd_s  cmd_i,             // Command payload.
  input  wire logic                 sector_nv_bit_i,   // Addressed sector.
  input  wire logic                 sector_vol_bit_i,  // Addressed sector.
  input  wire logic                 any_sector_lock_i, // Any sector locked.
  output sfwp_pkg::sfwp_status_s    status_o,          // Status bits.
  output logic                      main_grant_o,      // Main op may go.
  output logic                      main_deny_o,       // Main op refused.
  output logic                      otp_rvalid_o,      // OTP read done.
  output logic [7:0]                otp_rdata_o,       // OTP read byte.
  output logic                      otp_ecc_on_o       // Read chunk ECC.
);

  // Address slices need 7 to 32 bits; anything else fails elaboration.
  if (MAIN_AW < 7 || MAIN_AW > 32) begin : g_aw_check
    $error("MAIN_AW out of supported range");
  end

  // OTP bytes; programming can only clear bits.
  logic [7:0] otp_mem_r [sfwp_pkg::OTP_BYTES];
  // A chunk has seen its first program.
  logic [sfwp_pkg::OTP_CHUNKS-1:0] chunk_seen_r;
  // A chunk has lost correction through a second program.
  logic [sfwp_pkg::OTP_CHUNKS-1:0] chunk_ecc_off_r;

  logic       wel_r;          // Write enable latch.
  logic [2:0] bp_r;           // Block protect bits.
  logic       tb_r;           // Top/bottom select bit.
  logic       freeze_r;       // Protection freeze bit.
  logic       prog_err_r;     // Program error flag.
  logic       erase_err_r;    // Erase error flag.
  logic       grant_r;        // Registered grant pulse.
  logic       deny_r;         // Registered refusal pulse.
  logic       rvalid_r;       // Registered read strobe.
  logic [7:0] rdata_r;        // Registered read data.
  logic       ecc_on_r;       // Registered read chunk correction.

  logic       take;           // A command is taken this cycle.
  logic       otp_in_range;   // Command address inside the OTP space.
  logic [9:0] otp_addr;       // OTP byte address.
  logic [5:0] otp_chunk;      // Sixteen-byte chunk of the address.
  logic       sector_prot;    // Addressed main sector is protected.
  logic       main_prog;      // Main array program command.
  logic       main_erase;     // Main array erase command.
  logic       main_blocked;   // Main command would touch protection.
  logic       otp_go;         // OTP program writes the array.
  logic       otp_fail;       // OTP program fails with an error.
  logic       wel_clear_op;   // Command that ends with latch clear.

  // Returns one when the region holding addr has been locked.
  function automatic logic region_locked(input logic [9:0] addr);
    logic [4:0] region;
    logic [9:0] lock_addr;
    logic [7:0] lock_byte;
    region    = addr[9:sfwp_pkg::REGION_LSB];
    lock_addr = sfwp_pkg::LOCK_BASE + {8'h00, region[4:3]};
    lock_byte = otp_mem_r[lock_addr];
    if (region == 5'h00) begin
      // Only the upper half of region zero is lockable.
      region_locked = addr[4] & ~lock_byte[0];
    end else begin
      region_locked = ~lock_byte[region[2:0]];
    end
  endfunction

  // Hardware reset wins over any command in the same cycle.
  assign take         = cmd_valid_i & ~hw_reset_i;
  assign otp_in_range = (cmd_i.addr[31:sfwp_pkg::OTP_AW] == 22'h00_0000);
  assign otp_addr     = cmd_i.addr[9:0];
  assign otp_chunk    = cmd_i.addr[9:sfwp_pkg::CHUNK_LSB];

  assign main_prog  = (cmd_i.op == sfwp_pkg::op_page_program_command) |
                      (cmd_i.op == sfwp_pkg::op_quad_page_program_command);
  assign main_erase = (cmd_i.op == sfwp_pkg::op_sector_erase_command) |
                      (cmd_i.op == sfwp_pkg::op_bulk_erase_command);

  // Bulk erase touches every sector, so any protection blocks it.
  assign main_blocked =
    (cmd_i.op == sfwp_pkg::op_bulk_erase_command) ?
      ((bp_r != sfwp_pkg::BP_NONE) | any_sector_lock_i) :
      sector_prot;

  // OTP program outcome; the latch must be set for any effect.
  assign otp_fail = take & wel_r & otp_in_range &
                    (cmd_i.op == sfwp_pkg::op_otp_program_command) &
                    (freeze_r | region_locked(otp_addr));
  assign otp_go   = take & wel_r & otp_in_range &
                    (cmd_i.op == sfwp_pkg::op_otp_program_command) &
                    ~freeze_r & ~region_locked(otp_addr);

  // Commands that clear the latch as they complete; an out-of-range
  // OTP program is left out so the latch stays set.
  assign wel_clear_op =
    (cmd_i.op == sfwp_pkg::op_software_reset) |
    (cmd_i.op == sfwp_pkg::op_write_disable_command) |
    (cmd_i.op == sfwp_pkg::op_register_write_command) |
    main_prog | main_erase |
    ((cmd_i.op == sfwp_pkg::op_otp_program_command) &
     otp_in_range);

  // Protection decision for the addressed main-array sector.
  sfwp_range_chk #(
    .MAIN_AW (MAIN_AW)
  ) u_range_chk (
    .bp_i        (bp_r),
    .tb_i        (tb_r),
    .addr_i      (cmd_i.addr[MAIN_AW-1:0]),
    .nv_bit_i    (sector_nv_bit_i),
    .vol_bit_i   (sector_vol_bit_i),
    .protected_o (sector_prot)
  );

  // Write enable latch: set by its command, cleared by resets and by
  // the completion of the altering commands.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wel_r <= 1'b0;
    end else if (hw_reset_i) begin
      wel_r <= 1'b0;
    end else if (take) begin
      if (cmd_i.op == sfwp_pkg::op_write_enable_command) begin
        wel_r <= 1'b1;
      end else if (wel_clear_op) begin
        wel_r <= 1'b0;
      end
    end
  end

  // Block protection and freeze. Only power-on reset touches them; a
  // register write needs the latch and is ignored while frozen.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bp_r     <= sfwp_pkg::BP_RST;
      tb_r     <= sfwp_pkg::TB_RST;
      freeze_r <= sfwp_pkg::FREEZE_RST;
    end else if (take && wel_r &&
                 cmd_i.op == sfwp_pkg::op_register_write_command) begin
      if (!freeze_r) begin
        bp_r     <= cmd_i.block_protect_bits;
        tb_r     <= cmd_i.top_bottom_select_bit;
        freeze_r <= cmd_i.freeze;
      end
      // A frozen write keeps everything and flags nothing.
    end
  end

  // Error flags: set by failing operations, cleared by the clear
  // status command. A failure in the same cycle wins over the clear.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prog_err_r  <= 1'b0;
      erase_err_r <= 1'b0;
    end else if (take) begin
      if (otp_fail || (main_prog && wel_r && main_blocked)) begin
        prog_err_r <= 1'b1;
      end else if (cmd_i.op == sfwp_pkg::op_clear_status) begin
        prog_err_r <= 1'b0;
      end
      if (main_erase && wel_r && main_blocked) begin
        erase_err_r <= 1'b1;
      end else if (cmd_i.op == sfwp_pkg::op_clear_status) begin
        erase_err_r <= 1'b0;
      end
    end
  end

  // Main array gate: a pulse that lets or refuses the array operation.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      grant_r <= 1'b0;
      deny_r  <= 1'b0;
    end else begin
      grant_r <= take & wel_r & (main_prog | main_erase) & ~main_blocked;
      deny_r  <= take & wel_r & (main_prog | main_erase) &
                 main_blocked;
    end
  end

  // OTP array. Programs only clear bits and may repeat; there is no
  // erase command; only power-on reset reloads the erased pattern.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < sfwp_pkg::OTP_BYTES; i++) begin
        otp_mem_r[i] <= sfwp_pkg::ERASED_BYTE;
      end
    end else if (otp_go) begin
      otp_mem_r[otp_addr] <= otp_mem_r[otp_addr] & cmd_i.data;
    end
  end

  // Correction tracking per sixteen-byte chunk.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      chunk_seen_r    <= '0;
      chunk_ecc_off_r <= '0;
    end else if (otp_go) begin
      chunk_seen_r[otp_chunk] <= 1'b1;
      if (chunk_seen_r[otp_chunk]) begin
        chunk_ecc_off_r[otp_chunk] <= 1'b1;
      end
    end
  end

  // OTP read: in range returns the byte, out of range the erased
  // pattern, which the host must not rely on.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= sfwp_pkg::ERASED_BYTE;
      ecc_on_r <= 1'b0;
    end else begin
      rvalid_r <= take & (cmd_i.op == sfwp_pkg::op_otp_read_command);
      if (take && cmd_i.op == sfwp_pkg::op_otp_read_command) begin
        rdata_r  <= otp_in_range ? otp_mem_r[otp_addr] :
                    sfwp_pkg::ERASED_BYTE;
        ecc_on_r <= otp_in_range & ~chunk_ecc_off_r[otp_chunk];
      end
    end
  end

  // Status and strobes, each straight from a flip-flop.
  assign status_o.write_enable_latch    = wel_r;
  assign status_o.block_protect_bits    = bp_r;
  assign status_o.top_bottom_select_bit = tb_r;
  assign status_o.freeze                = freeze_r;
  assign status_o.prog_err              = prog_err_r;
  assign status_o.erase_err             = erase_err_r;
  assign main_grant_o = grant_r;
  assign main_deny_o  = deny_r;
  assign otp_rvalid_o = rvalid_r;
  assign otp_rdata_o  = rdata_r;
  assign otp_ecc_on_o = ecc_on_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i || hw_reset_i);

  // Latch set one cycle after write enable.
  a_wel_set_cmd: assert property (
    take && cmd_i.op == sfwp_pkg::op_write_enable_command |=> wel_r)
    else $error("latch not set by write enable");

  // Listed commands leave the latch clear.
  a_wel_clear_cmd: assert property (
    take && cmd_i.op != sfwp_pkg::op_write_enable_command &&
    (main_prog || main_erase ||
     cmd_i.op == sfwp_pkg::op_write_disable_command ||
     cmd_i.op == sfwp_pkg::op_register_write_command) |=> !wel_r)
    else $error("latch not cleared on completion");

  // Out-of-range OTP program keeps the latch, the error flag and the chunk tracking.
  a_otp_range_keep: assert property (
    take && wel_r && !otp_in_range &&
    cmd_i.op == sfwp_pkg::op_otp_program_command
    |=> wel_r && $stable(prog_err_r) && $stable(chunk_seen_r))
    else $error("out of range OTP program had an effect");

  // Frozen OTP program raises the program error.
  a_otp_freeze_err: assert property (
    take && wel_r && freeze_r && otp_in_range &&
    cmd_i.op == sfwp_pkg::op_otp_program_command
    |=> prog_err_r && $stable(chunk_seen_r))
    else $error("frozen OTP program did not fail");

  // Freeze holds once set until power-on reset.
  a_freeze_sticky: assert property (
    freeze_r |=> freeze_r [*4])
    else $error("freeze bit cleared");

  // Frozen protection bits hold still.
  a_bp_frozen_hold: assert property (
    freeze_r |=> $stable(bp_r) && $stable(tb_r) && ($stable(prog_err_r) ||
    !$past(take && cmd_i.op == sfwp_pkg::op_register_write_command)))
    else $error("frozen protection bits changed");

  // Unfrozen register write loads the new bits.
  a_bp_write_load: assert property (
    take && wel_r && !freeze_r &&
    cmd_i.op == sfwp_pkg::op_register_write_command
    |=> bp_r == $past(cmd_i.block_protect_bits) &&
        tb_r == $past(cmd_i.top_bottom_select_bit))
    else $error("register write did not load bits");

  // Protected main program is refused and flagged.
  a_main_prot_deny: assert property (
    take && wel_r && main_prog && main_blocked
    |=> deny_r && !grant_r && prog_err_r)
    else $error("protected program not refused");

  // Second program in a chunk turns correction off.
  a_ecc_second_off: assert property (
    otp_go && chunk_seen_r[otp_chunk] |=> chunk_ecc_off_r[$past(otp_chunk)])
    else $error("second chunk program kept correction");

  c_frozen_otp: cover property (otp_fail && freeze_r);
  c_main_grant: cover property (grant_r);
  c_otp_read:   cover property (rvalid_r && ecc_on_r);
  c_ecc_lost:   cover property (otp_go && chunk_seen_r[otp_chunk]);

endmodule

//--- pkg/sfwp_pkg.sv
// Shared constants, command codes and carriers for the flash write
// protection block.
// Assumes a single clock domain; every user includes nothing, it names
// each item as sfwp_pkg::name.
package sfwp_pkg;

  // One-time-programmable space geometry.
  localparam int unsigned OTP_BYTES   = 1024;
  localparam int unsigned OTP_AW      = 10;
  localparam int unsigned OTP_CHUNKS  = 64;
  localparam int unsigned CHUNK_LSB   = 4;
  localparam int unsigned REGION_LSB  = 5;
  // Address of the first lock byte, inside region zero.
  localparam logic [9:0]  LOCK_BASE   = 10'h010;
  // Value of an unprogrammed byte, also returned for reads out of range.
  localparam logic [7:0]  ERASED_BYTE = 8'hff;

  // Block protect field.
  localparam int unsigned BP_W        = 3;
  localparam logic [2:0]  BP_NONE     = 3'h0;
  localparam logic [2:0]  BP_ALL      = 3'h7;

  // Values after power-on reset.
  localparam logic [2:0]  BP_RST      = 3'h0;
  localparam logic        TB_RST      = 1'b0;
  localparam logic        FREEZE_RST  = 1'b0;

  // Main array address width in bytes (64 Mbyte).
  localparam int unsigned MAIN_AW     = 26;

  // Commands as decoded by the serial front end.
  typedef enum logic [3:0] {
    op_none,
    op_write_enable_command,
    op_write_disable_command,
    op_register_write_command,
    op_page_program_command,
    op_quad_page_program_command,
    op_sector_erase_command,
    op_bulk_erase_command,
    op_otp_program_command,
    op_otp_read_command,
    op_software_reset,
    op_clear_status
  } sfwp_op_e;

  // One decoded command with its operands.
  typedef struct packed {
    sfwp_op_e    op;
    logic [31:0] addr;
    logic [7:0]  data;
    logic [2:0]  block_protect_bits;
    logic        top_bottom_select_bit;
    logic        freeze;
  } sfwp_cmd_s;

  // Status seen by the host.
  typedef struct packed {
    logic        write_enable_latch;
    logic [2:0]  block_protect_bits;
    logic        top_bottom_select_bit;
    logic        freeze;
    logic        prog_err;
    logic        erase_err;
  } sfwp_status_s;

endpackage

//--- hw/sfwp_range_chk.sv
// Sector protection decision for one main-array address.
// Assumes the sector bits for the addressed sector are presented by the
// per-sector protection store alongside the address.
`timescale 1ns/1ps
module sfwp_range_chk #(
  parameter int unsigned MAIN_AW = sfwp_pkg::MAIN_AW
) (
  input  wire logic [2:0]         bp_i,        // Block protect bits.
  input  wire logic               tb_i,        // Top/bottom select bit.
  input  wire logic [MAIN_AW-1:0] addr_i,      // Main array address.
  input  wire logic               nv_bit_i,    // Nonvolatile sector bit.
  input  wire logic               vol_bit_i,   // Volatile sector bit.
  output logic                    protected_o  // Sector may not change.
);

  // The fraction walk needs six address bits above the sector size, so
  // narrower arrays are refused at elaboration.
  if (MAIN_AW < 7) begin : g_aw_check
    $error("MAIN_AW too small for block protection");
  end

  logic       blk_hit;  // Block protection covers the address.
  logic       match;    // Running compare of the top address bits.
  logic [2:0] nbits;    // How many top address bits must match.

  // A code k from 1 to 6 protects 1/2^(7-k) of the array, so that many
  // top bits must be all ones from the top or all zeros from the bottom.
  always_comb begin
    blk_hit = 1'b0;
    match   = 1'b1;
    nbits   = 3'(3'h7 - bp_i);
    if (bp_i == sfwp_pkg::BP_ALL) begin
      blk_hit = 1'b1;
    end else if (bp_i != sfwp_pkg::BP_NONE) begin
      for (int i = 0; i < 6; i++) begin
        if (i < int'(nbits)) begin
          match = match & (addr_i[MAIN_AW-1-i] == ~tb_i);
        end
      end
      blk_hit = match;
    end
  end

  // Either scheme protecting the sector is enough.
  assign protected_o = blk_hit | ~nv_bit_i | ~vol_bit_i;

endmodule

//--- verification/sfwp_host_model.sv
// Host controller model that presents one decoded command per call.
// Assumes the bench paces the calls; the core takes commands on rising
// edges, so every line changes only on falling edges here.
`timescale 1ns/1ps
module sfwp_host_model (
  input  wire logic           clk_i,       // Core clock.
  output logic                cmd_valid_o, // Command strobe.
  output sfwp_pkg::sfwp_cmd_s cmd_o,       // Command payload.
  output logic [2:0]          sector_o     // Nonvolatile, volatile, any.
);
  // Lines start quiet, with a known pattern on every payload bit.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o       = '0;
    sector_o    = 3'h7;
  end

  // Drives a command from the next falling edge and leaves it standing,
  // so calls on consecutive cycles give back-to-back commands.
  task automatic send(input sfwp_pkg::sfwp_cmd_s c, input logic [2:0] sb);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_o       = c;
    sector_o    = sb;
  endtask

  // Drops the strobe; address, data and sector lines flip so a stale value never matches.
  task automatic idle();
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_o.addr  = ~cmd_o.addr;
    cmd_o.data  = ~cmd_o.data;
    sector_o    = ~sector_o;
  endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the write protection core with a reference
// model that predicts status, pulses and read data of every command.
// Assumes the host model in sfwp_host_model.sv and the core's package.
`timescale 1ns/1ps
module testbench;
  // One predicted result: status plus the pulse and read outputs.
  typedef struct packed {
    sfwp_pkg::sfwp_status_s st;
    logic                   grant;
    logic                   deny;
    logic                   rvalid;
    logic [7:0]             rdata;
    logic                   ecc;
  } sfwp_note_s;
  // Short names for the decoded commands.
  localparam sfwp_pkg::sfwp_op_e C_LATCH = sfwp_pkg::op_write_enable_command;
  localparam sfwp_pkg::sfwp_op_e C_UNLAT = sfwp_pkg::op_write_disable_command;
  localparam sfwp_pkg::sfwp_op_e C_REGW = sfwp_pkg::op_register_write_command;
  localparam sfwp_pkg::sfwp_op_e C_PROG = sfwp_pkg::op_page_program_command;
  localparam sfwp_pkg::sfwp_op_e C_QPRG =
    sfwp_pkg::op_quad_page_program_command;
  localparam sfwp_pkg::sfwp_op_e C_SERS = sfwp_pkg::op_sector_erase_command;
  localparam sfwp_pkg::sfwp_op_e C_BERS = sfwp_pkg::op_bulk_erase_command;
  localparam sfwp_pkg::sfwp_op_e C_OTPW = sfwp_pkg::op_otp_program_command;
  localparam sfwp_pkg::sfwp_op_e C_OTPRD = sfwp_pkg::op_otp_read_command;
  localparam sfwp_pkg::sfwp_op_e C_SWRST = sfwp_pkg::op_software_reset;
  localparam sfwp_pkg::sfwp_op_e C_CLR = sfwp_pkg::op_clear_status;

  logic                   clk_i;       // Core clock.
  logic                   reset_i;     // Power-on reset.
  logic                   hw_reset_i;  // Hardware reset.
  logic                   cmd_valid_i; // Command strobe.
  sfwp_pkg::sfwp_cmd_s    cmd_i;       // Command payload.
  logic [2:0]             sector;      // Sector bits and any-lock flag.
  sfwp_pkg::sfwp_status_s status_o;    // Status from the core.
  logic                   main_grant_o;
  logic                   main_deny_o;
  logic                   otp_rvalid_o;
  logic [7:0]             otp_rdata_o;
  logic                   otp_ecc_on_o;
  sfwp_pkg::sfwp_status_s m_st;        // Predicted status.
  logic [7:0]             m_otp [1024]; // Predicted OTP array.
  int unsigned            m_cnt [64];  // Programs seen per 16 bytes.
  logic [7:0]             m_rd;        // Predicted last read byte.
  logic                   m_ecc;       // Predicted last correction state.
  sfwp_note_s             notes [$];   // Results still expected.
  sfwp_note_s             cur;         // Result under comparison.
  logic                   taken;       // A command was taken.
  int                     num_errors;
  int                     checks_done;

  sfwp_host_model host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i),
                        .cmd_o(cmd_i), .sector_o(sector));
  sfwp_top uut (.clk_i(clk_i), .reset_i(reset_i), .hw_reset_i(hw_reset_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .sector_nv_bit_i(sector[2]),
    .sector_vol_bit_i(sector[1]), .any_sector_lock_i(sector[0]),
    .status_o(status_o), .main_grant_o(main_grant_o),
    .main_deny_o(main_deny_o), .otp_rvalid_o(otp_rvalid_o),
    .otp_rdata_o(otp_rdata_o), .otp_ecc_on_o(otp_ecc_on_o));

  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Returns whether the block protect setting covers a main address.
  function automatic logic in_blk(input logic [25:0] a);
    logic [26:0] sz;
    sz = 27'h400_0000 >> (7 - m_st.block_protect_bits);
    if (m_st.block_protect_bits == 3'h0) return 1'b0;
    if (m_st.top_bottom_select_bit) return {1'b0, a} < sz;
    return {1'b0, a} >= 27'h400_0000 - sz;
  endfunction

  // Puts the model into its power-on state.
  task automatic m_reset();
    m_st  = '0;
    m_rd  = 8'hff;
    m_ecc = 1'b0;
    foreach (m_otp[i]) m_otp[i] = 8'hff;
    foreach (m_cnt[i]) m_cnt[i] = 0;
  endtask

  // Predicts one command, notes the result, then hands it to the host.
  task automatic do_cmd(input sfwp_pkg::sfwp_op_e op, input logic [31:0] a,
    input logic [7:0] d, input logic [4:0] pr, input logic [2:0] sb);
    sfwp_note_s n;
    logic       prot;
    logic [4:0] r;
    n    = '0;
    r    = a[9:5];
    prot = in_blk(a[25:0]) | ~sb[2] | ~sb[1];
    if (op == C_LATCH) begin
      m_st.write_enable_latch = 1'b1;
    end else if (op == C_OTPRD) begin
      n.rvalid = 1'b1;
      m_rd  = (a < 32'h0000_0400) ? m_otp[a[9:0]] : 8'hff;
      m_ecc = (a < 32'h0000_0400) && (m_cnt[a[9:4]] < 2);
    end else if (op == C_CLR) begin
      m_st.prog_err  = 1'b0;
      m_st.erase_err = 1'b0;
    end else if (m_st.write_enable_latch) begin
      m_st.write_enable_latch = 1'b0;
      if (op == C_REGW && !m_st.freeze) begin
        {m_st.block_protect_bits, m_st.top_bottom_select_bit,
         m_st.freeze} = pr;
      end else if (op inside {C_PROG, C_QPRG, C_SERS, C_BERS}) begin
        if (op == C_BERS) prot = (m_st.block_protect_bits != 3'h0) | sb[0];
        n.grant = ~prot;
        n.deny  = prot;
        if (prot && op inside {C_SERS, C_BERS}) m_st.erase_err = 1'b1;
        else if (prot) m_st.prog_err = 1'b1;
      end else if (op == C_OTPW && a >= 32'h0000_0400) begin
        m_st.write_enable_latch = 1'b1;
      end else if (op == C_OTPW && (m_st.freeze ||
          (!m_otp[10'h010 + r[4:3]][r[2:0]] && (r != 0 || a[4])))) begin
        m_st.prog_err = 1'b1;
      end else if (op == C_OTPW) begin
        m_otp[a[9:0]] = m_otp[a[9:0]] & d;
        m_cnt[a[9:4]]++;
      end
    end
    n.st    = m_st;
    n.rdata = m_rd;
    n.ecc   = m_ecc;
    notes.push_back(n);
    host.send(sfwp_pkg::sfwp_cmd_s'{op, a, d, pr[4:2], pr[1], pr[0]}, sb);
  endtask

  // Sets the latch first, as a careful host always does.
  task automatic wr(input sfwp_pkg::sfwp_op_e op, input logic [31:0] a,
    input logic [7:0] d, input logic [4:0] pr, input logic [2:0] sb);
    do_cmd(C_LATCH, 32'h0, 8'h00, 5'h00, 3'h7);
    do_cmd(op, a, d, pr, sb);
  endtask

  // Compares the status word.
  task automatic check_st(input sfwp_pkg::sfwp_status_s e);
    checks_done++;
    if (status_o !== e) begin
      num_errors++;
      $display("mismatch at %0t: status exp %h got %h", $time, e, status_o);
    end
  endtask

  // Compares the pulses and the read outputs.
  task automatic check_out(input sfwp_note_s e);
    checks_done++;
    if ({main_grant_o, main_deny_o, otp_rvalid_o, otp_rdata_o, otp_ecc_on_o}
        !== {e.grant, e.deny, e.rvalid, e.rdata, e.ecc}) begin
      num_errors++;
      $display("mismatch at %0t: outputs differ, read %h", $time, e.rdata);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Takes the oldest note on the falling edge half a cycle after each taken command.
  always begin
    @(posedge clk_i);
    taken = cmd_valid_i & ~hw_reset_i & ~reset_i;
    @(negedge clk_i);
    if (taken && notes.size() == 0) begin
      num_errors++;
      $display("mismatch at %0t: result with no note", $time);
    end else if (taken) begin
      cur = notes.pop_front();
      check_st(cur.st);
      check_out(cur);
    end
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("mismatch at %0t: run timed out", $time);
    complete_run();
  end

  // Main sequence.
  initial begin
    sfwp_pkg::sfwp_op_e clr [8];
    sfwp_pkg::sfwp_op_e mop [4];
    logic [31:0]        ra [7];
    logic [26:0]        sz;
    logic [25:0]        eg;
    logic [25:0]        ad [5];
    clr = '{C_SWRST, C_PROG, C_SERS, C_BERS, C_UNLAT, C_REGW, C_QPRG, C_OTPW};
    mop = '{C_PROG, C_QPRG, C_SERS, C_BERS};
    num_errors  = 0;
    checks_done = 0;
    reset_i     = 1'b1;
    hw_reset_i  = 1'b0;
    m_reset();
    void'($urandom(42168));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    // Latch: ignored without it, cleared by each listed command and reset.
    do_cmd(C_PROG, 32'h0, 8'h00, 5'h00, 3'h7);
    foreach (clr[i]) wr(clr[i], 32'h20, 8'h00, 5'h00, 3'h7);
    do_cmd(C_LATCH, 32'h0, 8'h00, 5'h00, 3'h7);
    host.send(sfwp_pkg::sfwp_cmd_s'{C_LATCH, 32'h0, 8'h00, 3'h0, 1'b0,
                                    1'b0}, 3'h7);
    hw_reset_i = 1'b1;
    m_st.write_enable_latch = 1'b0;
    host.idle();
    hw_reset_i = 1'b0;
    do_cmd(C_OTPRD, 32'h0000_0020, 8'h00, 5'h00, 3'h7);
    $display("test latch done");
    // Every protect code from both ends, with edge addresses.
    for (int k = 0; k < 16; k++) begin
      wr(C_REGW, 32'h0, 8'h00, {k[2:0], k[3], 1'b0}, 3'h7);
      sz = 27'h400_0000 >> (7 - k[2:0]);
      eg = k[3] ? sz[25:0] : 26'(27'h400_0000 - sz);
      ad = '{26'h0, 26'h3ff_ffff, eg - 26'h1, eg, 26'($urandom)};
      for (int i = 0; i < 5; i++) begin
        wr(i[0] ? C_SERS : C_PROG, 32'(ad[i]), 8'h0, 5'h0, 3'h7);
      end
    end
    do_cmd(C_CLR, 32'h0, 8'h00, 5'h00, 3'h7);
    $display("test block protect done");
    // Sector bits only, block protection off.
    wr(C_REGW, 32'h0, 8'h00, 5'h00, 3'h7);
    for (int i = 0; i < 40; i++) begin
      wr(mop[i % 4], $urandom, 8'h00, 5'h00, 3'($urandom));
    end
    do_cmd(C_CLR, 32'h0, 8'h00, 5'h00, 3'h7);
    $display("test sector bits done");
    // OTP: range, repeats, correction and the lock bytes.
    wr(C_OTPW, 32'h0000_0400, 8'h00, 5'h00, 3'h7);
    do_cmd(C_OTPW, 32'h0000_03ff, 8'h5a, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_03ff, 8'h0f, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0300, 8'h33, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0011, 8'hfb, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0140, 8'h00, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0120, 8'h00, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0010, 8'hfe, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0013, 8'h00, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0005, 8'h00, 5'h00, 3'h7);
    ra = '{32'h3ff, 32'h300, 32'h400, 32'h140, 32'h120, 32'h13, 32'h5};
    foreach (ra[i]) do_cmd(C_OTPRD, ra[i], 8'h00, 5'h00, 3'h7);
    do_cmd(C_CLR, 32'h0, 8'h00, 5'h00, 3'h7);
    $display("test otp done");
    // Freeze holds the bits against a register write, fails OTP programs, clears on power-on reset.
    wr(C_REGW, 32'h0, 8'h00, 5'h17, 3'h7);
    wr(C_REGW, 32'h0, 8'h00, 5'h00, 3'h7);
    wr(C_OTPW, 32'h0000_0200, 8'h00, 5'h00, 3'h7);
    wr(C_PROG, 32'h0, 8'h00, 5'h00, 3'h7);
    host.idle();
    @(negedge clk_i);
    reset_i = 1'b1;
    m_reset();
    @(negedge clk_i);
    reset_i = 1'b0;
    wr(C_REGW, 32'h0, 8'h00, 5'h0c, 3'h7);
    do_cmd(C_OTPRD, 32'h0000_03ff, 8'h00, 5'h00, 3'h7);
    $display("test freeze done");
    host.idle();
    for (int i = 0; i < 4 && notes.size() != 0; i++) @(negedge clk_i);
    if (notes.size() != 0) begin
      num_errors++;
      $display("mismatch at %0t: results missing", $time);
    end
    complete_run();
  end
endmodule
